// ---- hw/acc_adc_ctrl.sv ----
// converter control: configuration, conversion timing and result correction
// Operation
// RULE1 - sample period field [15:13] sets conversion length 32 << field converter clocks
// RULE2 - resolution is seven bits plus one per period step, fourteen at seven
// RULE3 - result register holds read-only 16-bit two's complement value
// RULE4 - result is left-justified, msb always at bit 15
// RULE5 - software writes zero to configuration bits 12 and 11
// RULE6 - software writes zero to configuration bit 1
// RULE7 - positive input selector bits 10..7, codes 0x0..0x5 pick external pins
// RULE8 - codes 0x8..0xb pick ground, half reference, reference, half pad supply
// RULE9 - software never programs selector codes 0x6, 0x7, 0xc..0xf
// RULE10 - negative input selector bits 6..3 uses the same code table
// RULE11 - bit 2 picks converter clock, zero 6 MHz, one 1 MHz
// RULE12 - bit 0 one runs continuous conversions, zero stops them
// RULE13 - first conversion after start takes double clocks plus 21 us
// RULE14 - configuration write while running doubles the next conversion
// RULE15 - signed 16-bit offset added to raw result before gain
// RULE16 - unsigned gain with binary point below bit 15 multiplies result
// RULE17 - result updated once per conversion, saturating on overflow
// RULE18 - timing counter restarts on enable or configuration rewrite
//
// Strobed register access was left to the implementer.
module acc_adc_ctrl (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire acc_pkg::acc_bus_req_t bus_req,
   output logic [31:0] bus_rdata,
   input wire logic [15:0] raw_sample,
   output logic [3:0] positive_input_select,
   output logic [3:0] negative_input_select,
   output logic slow_clock_select,
   output logic converter_run,
   output logic result_valid
);

   acc_pkg::acc_cfg_t cfg_reg;
   logic [15:0] offset_reg;
   logic [15:0] gain_reg;
   logic [15:0] result_reg;
   logic [31:0] rdata_reg;
   logic [15:0] raw_meta_reg;
   logic [15:0] raw_sync_reg;
   logic [3:0] phase_reg;
   logic [3:0] phase_next;
   logic tick;
   acc_pkg::acc_state_t state_reg;
   logic [7:0] warm_cnt_reg;
   logic [12:0] conv_cnt_reg;
   logic long_reg;
   logic valid_reg;
   logic [12:0] conv_target;
   logic [15:0] masked_raw;
   logic [15:0] corrected;
   logic cfg_wr;
   acc_pkg::acc_cfg_t cfg_wdata;

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = (addr == target);
   endfunction : hit

   // converter clocks for one conversion, doubled when lengthened
   function automatic logic [12:0] conv_clocks(input logic [2:0] period, input logic dbl);
      logic [12:0] base;
      base = 13'(acc_pkg::ACC_BASE_CLOCKS) << period; // [RULE1]
      // period 7 doubled wraps to zero; the 13-bit count wraps with it, so the length holds
      conv_clocks = dbl ? (base << 1) : base; // [RULE13] [RULE14]
   endfunction : conv_clocks

   // drop bits below the resolution of the chosen period
   function automatic logic [15:0] quantize(input logic [15:0] raw, input logic [2:0] period);
      logic [3:0] kept;
      kept = 4'(acc_pkg::ACC_MIN_BITS) + {1'b0, period}; // [RULE2]
      quantize = raw & (16'hffff << (5'd16 - {1'b0, kept})); // [RULE4]
   endfunction : quantize

   // offset then gain, clamped to the signed 16-bit range
   function automatic logic [15:0] correct(input logic [15:0] raw, input logic [15:0] offs,
                                           input logic [15:0] gain);
      logic signed [16:0] sum;
      logic signed [33:0] prod;
      logic signed [33:0] scaled;
      sum = $signed({raw[15], raw}) + $signed({offs[15], offs}); // [RULE15]
      prod = 34'(sum * $signed({1'b0, gain})); // [RULE16]
      scaled = prod >>> acc_pkg::ACC_GAIN_FRAC_BITS;
      if (scaled > 34'sh0000_07fff) begin // [RULE17]
         correct = 16'h7fff;
      end else if (scaled < -34'sh0000_08000) begin
         correct = 16'h8000;
      end else begin
         correct = scaled[15:0];
      end
   endfunction : correct

   assign cfg_wr = bus_req.wr && hit(bus_req.addr, acc_pkg::ACC_CONFIG_ADDR);
   assign cfg_wdata = acc_pkg::acc_cfg_t'(bus_req.wdata[15:0]);
   assign conv_target = conv_clocks(cfg_reg.sample_period, long_reg);
   assign masked_raw = quantize(raw_sync_reg, cfg_reg.sample_period);
   assign corrected = correct(masked_raw, offset_reg, gain_reg);

   // reserved bits are stored as written; software keeps them zero
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg_reg <= acc_pkg::acc_cfg_t'(acc_pkg::ACC_CONFIG_RESET);
         offset_reg <= acc_pkg::ACC_OFFSET_RESET;
         gain_reg <= acc_pkg::ACC_GAIN_RESET;
      end else if (bus_req.wr) begin
         if (cfg_wr) begin
            cfg_reg <= cfg_wdata; // [RULE5] [RULE6] [RULE9]
         end else if (hit(bus_req.addr, acc_pkg::ACC_OFFSET_ADDR)) begin
            offset_reg <= bus_req.wdata[15:0];
         end else if (hit(bus_req.addr, acc_pkg::ACC_GAIN_ADDR)) begin
            gain_reg <= bus_req.wdata[15:0];
         end
      end
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdata_reg <= 32'h0000_0000;
      end else if (!bus_req.rd) begin
         rdata_reg <= 32'h0000_0000;
      end else if (hit(bus_req.addr, acc_pkg::ACC_RESULT_ADDR)) begin
         rdata_reg <= {16'h0000, result_reg}; // [RULE3]
      end else if (hit(bus_req.addr, acc_pkg::ACC_CONFIG_ADDR)) begin
         rdata_reg <= {16'h0000, cfg_reg};
      end else if (hit(bus_req.addr, acc_pkg::ACC_OFFSET_ADDR)) begin
         rdata_reg <= {16'h0000, offset_reg};
      end else if (hit(bus_req.addr, acc_pkg::ACC_GAIN_ADDR)) begin
         rdata_reg <= {16'h0000, gain_reg};
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // analog core word arrives on its own timing
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         raw_meta_reg <= 16'h0000;
         raw_sync_reg <= 16'h0000;
      end else begin
         raw_meta_reg <= raw_sample;
         raw_sync_reg <= raw_meta_reg;
      end
   end

   // 6 or 1 MHz from 10 MHz: phase accumulator, so 6 MHz ticks are uneven but the mean rate is exact
   always_comb begin
      logic [4:0] sum;
      sum = 5'd0;
      sum = {1'b0, phase_reg} + (cfg_reg.slow_clock_select ? 5'(acc_pkg::ACC_SLOW_MHZ)
                                                           : 5'(acc_pkg::ACC_FAST_MHZ)); // [RULE11]
      tick = (sum >= 5'(acc_pkg::ACC_CORE_MHZ));
      phase_next = tick ? 4'(sum - 5'(acc_pkg::ACC_CORE_MHZ)) : sum[3:0];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         phase_reg <= 4'h0;
      end else if (cfg_wr) begin
         // restart the tick phase too, so a length after a write does not drift by a tick
         phase_reg <= 4'h0; // [RULE18]
      end else begin
         phase_reg <= phase_next;
      end
   end

   // conversion sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_reg <= acc_pkg::ACC_IDLE;
         warm_cnt_reg <= 8'h00;
         conv_cnt_reg <= 13'h0000;
         long_reg <= 1'b0;
      end else if (cfg_wr && !cfg_wdata.enable) begin
         state_reg <= acc_pkg::ACC_IDLE; // [RULE12]
         warm_cnt_reg <= 8'h00;
         conv_cnt_reg <= 13'h0000;
         long_reg <= 1'b0;
      end else if (cfg_wr && state_reg == acc_pkg::ACC_CONV) begin
         conv_cnt_reg <= 13'h0000; // [RULE14] [RULE18]
         long_reg <= 1'b1;
      end else if (cfg_wr) begin
         state_reg <= acc_pkg::ACC_WARM; // [RULE12] [RULE13]
         warm_cnt_reg <= 8'h00; // [RULE18]
         conv_cnt_reg <= 13'h0000;
         long_reg <= 1'b1;
      end else begin
         case (state_reg)
            acc_pkg::ACC_WARM: begin
               if (warm_cnt_reg == 8'(acc_pkg::ACC_WARMUP_CYCLES - 1)) begin
                  state_reg <= acc_pkg::ACC_CONV; // [RULE13]
                  warm_cnt_reg <= 8'h00;
               end else begin
                  warm_cnt_reg <= warm_cnt_reg + 8'h01;
               end
            end
            acc_pkg::ACC_CONV: begin
               if (tick && conv_cnt_reg == conv_target - 13'h0001) begin
                  conv_cnt_reg <= 13'h0000; // [RULE1]
                  long_reg <= 1'b0;
               end else if (tick) begin
                  conv_cnt_reg <= conv_cnt_reg + 13'h0001;
               end
            end
            default: begin
               state_reg <= acc_pkg::ACC_IDLE;
            end
         endcase
      end
   end

   // capture a corrected result at the end of each conversion
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         result_reg <= acc_pkg::ACC_RESULT_RESET;
         valid_reg <= 1'b0;
      end else if (!cfg_wr && state_reg == acc_pkg::ACC_CONV && tick
                   && conv_cnt_reg == conv_target - 13'h0001) begin
         result_reg <= corrected; // [RULE17]
         valid_reg <= 1'b1;
      end else begin
         valid_reg <= 1'b0;
      end
   end

   // analog mux codes go straight from the configuration flops
   assign positive_input_select = cfg_reg.positive_input_select; // [RULE7] [RULE8]
   assign negative_input_select = cfg_reg.negative_input_select; // [RULE10]
   assign slow_clock_select = cfg_reg.slow_clock_select; // [RULE11]
   assign converter_run = cfg_reg.enable;
   assign result_valid = valid_reg;
   assign bus_rdata = rdata_reg;

   default clocking acc_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence cfg_start_s;
      cfg_wr && cfg_wdata.enable && state_reg == acc_pkg::ACC_IDLE;
   endsequence

   sequence cfg_change_s;
      cfg_wr && cfg_wdata.enable && state_reg == acc_pkg::ACC_CONV;
   endsequence

   AST_LENGTH: assert property ( // [RULE1]
      result_valid |-> $past(conv_cnt_reg) + 13'h0001 == $past(conv_target))
      else $error("conversion ended at the wrong count");

   AST_RESOLUTION: assert property ( // [RULE2]
      cfg_reg.sample_period == 3'h7 |-> masked_raw[1:0] == 2'b00
         && masked_raw[15:2] == raw_sync_reg[15:2])
      else $error("fourteen-bit resolution not kept");

   AST_HOLD: assert property ( // [RULE3]
      !result_valid |=> $stable(result_reg) || result_valid)
      else $error("result changed without a conversion");

   AST_JUSTIFY: assert property ( // [RULE4]
      cfg_reg.sample_period == 3'h0 |-> masked_raw[8:0] == 9'h000)
      else $error("low bits not cleared at shortest period");

   AST_MUX: assert property ( // [RULE7]
      cfg_wr |=> positive_input_select == $past(cfg_wdata.positive_input_select)
         && negative_input_select == $past(cfg_wdata.negative_input_select))
      else $error("input selectors not following configuration");

   AST_SLOW_RATE: assert property ( // [RULE11]
      slow_clock_select && tick && !cfg_wr |=> (!tick || !slow_clock_select) [*8])
      else $error("slow converter clock ticking too fast");

   AST_START: assert property ( // [RULE13]
      cfg_start_s |=> state_reg == acc_pkg::ACC_WARM && long_reg && warm_cnt_reg == 8'h00)
      else $error("start did not enter the settling phase");

   AST_WARM_LEN: assert property ( // [RULE13]
      $rose(state_reg == acc_pkg::ACC_CONV) |->
         $past(warm_cnt_reg) == 8'(acc_pkg::ACC_WARMUP_CYCLES - 1))
      else $error("settling phase length wrong");

   AST_STOP: assert property ( // [RULE12]
      cfg_wr && !cfg_wdata.enable |=> state_reg == acc_pkg::ACC_IDLE && !result_valid)
      else $error("conversions did not stop");

   AST_RECONFIG: assert property ( // [RULE14]
      cfg_change_s |=> conv_cnt_reg == 13'h0000 && long_reg && !result_valid)
      else $error("reconfiguration did not restart a long conversion");

   AST_CAPTURE: assert property ( // [RULE17]
      result_valid |-> result_reg == $past(corrected))
      else $error("stored result differs from corrected value");

   AST_SATURATE: assert property ( // [RULE15]
      offset_reg == 16'h7fff && gain_reg == acc_pkg::ACC_GAIN_RESET
         && !masked_raw[15] |-> corrected == 16'h7fff)
      else $error("offset overflow did not saturate");

   AST_PHASE_RESTART: assert property ( // [RULE18]
      cfg_wr |=> phase_reg == 4'h0)
      else $error("tick phase not restarted by configuration write");

   AST_IDLE_READ: assert property ( // [RULE3]
      !bus_req.rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data shown without a read strobe");

endmodule : acc_adc_ctrl

// ---- hw/acc_pkg.sv ----
// constants, field layouts and carrier types for the converter control block
package acc_pkg;

   // register byte addresses
   localparam logic [31:0] ACC_RESULT_ADDR = 32'h4000d000;
   localparam logic [31:0] ACC_CONFIG_ADDR = 32'h4000d004;
   localparam logic [31:0] ACC_OFFSET_ADDR = 32'h4000d008;
   localparam logic [31:0] ACC_GAIN_ADDR = 32'h4000d00c;

   // reset values
   localparam logic [15:0] ACC_RESULT_RESET = 16'h0000;
   localparam logic [15:0] ACC_CONFIG_RESET = 16'h1800;
   localparam logic [15:0] ACC_OFFSET_RESET = 16'h0000;
   localparam logic [15:0] ACC_GAIN_RESET = 16'h8000;

   // conversion length and resolution
   localparam int ACC_BASE_CLOCKS = 32;
   localparam int ACC_MIN_BITS = 7;
   localparam int ACC_GAIN_FRAC_BITS = 15;

   // clock rates in MHz; converter clock made by a fractional divider
   localparam int ACC_CORE_MHZ = 10;
   localparam int ACC_FAST_MHZ = 6;
   localparam int ACC_SLOW_MHZ = 1;

   // settling time added to the first conversion after start
   localparam int ACC_WARMUP_NS = 21000;
   localparam int ACC_WARMUP_CYCLES = (ACC_WARMUP_NS * ACC_CORE_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_WARM = 2'b01,
      ACC_CONV = 2'b10
   } acc_state_t;

   // configuration word, bits 15..0
   typedef struct packed {
      logic [2:0] sample_period;
      logic [1:0] reserved_pair;
      logic [3:0] positive_input_select;
      logic [3:0] negative_input_select;
      logic slow_clock_select;
      logic reserved_single;
      logic enable;
   } acc_cfg_t;

   // register port request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } acc_bus_req_t;

endpackage : acc_pkg

// ---- verif/acc_analog_model.sv ----
// analog front end model: input pins and internal references feeding the converter
module acc_analog_model (
   input wire logic [3:0] positive_input_select,
   input wire logic [3:0] negative_input_select,
   output logic [15:0] raw_sample
);
   timeunit 1ns;
   timeprecision 1ns;

   // pin levels carry low bits so that quantisation shows
   function automatic logic [15:0] level(logic [3:0] code);
      case (code)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: return 16'h0923 + {code[2:0], 11'h000};
         4'h8: return 16'h0000;
         4'h9: return 16'h3000;
         4'ha: return 16'h6000;
         4'hb: return 16'h2400;
         default: return 16'h5a5a;
      endcase
   endfunction : level

   assign raw_sample = level(positive_input_select) - level(negative_input_select);
endmodule : acc_analog_model

// ---- verif/testbench.sv ----
// register-level testbench for the converter control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [2:0] p;
      logic [3:0] pos;
      logic [3:0] neg;
      logic slow;
      logic [15:0] off;
      logic [15:0] g;
   } acc_case_t;
   logic core_clk;
   logic rst_b;
   acc_pkg::acc_bus_req_t bus_req;
   logic [31:0] bus_rdata;
   logic [15:0] raw_sample;
   logic [3:0] positive_input_select;
   logic [3:0] negative_input_select;
   logic slow_clock_select;
   logic converter_run;
   logic result_valid;
   int n_errors;
   int checks;
   int n;
   int ticks;
   logic [31:0] rdat;
   logic [15:0] exp_res;
   acc_pkg::acc_cfg_t cfg;
   acc_case_t cases [5] = '{
      '{3'd0, 4'h0, 4'h8, 1'b0, 16'h0000, 16'h8000},
      '{3'd2, 4'h3, 4'h9, 1'b0, 16'hff00, 16'h4000},
      '{3'd7, 4'h5, 4'hb, 1'b0, 16'h0010, 16'h8000},
      '{3'd1, 4'ha, 4'h8, 1'b1, 16'h7fff, 16'h8000},
      '{3'd0, 4'h8, 4'ha, 1'b0, 16'h9000, 16'hffff}};

   acc_adc_ctrl u_acc_adc_ctrl (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .raw_sample(raw_sample),
      .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .slow_clock_select(slow_clock_select),
      .converter_run(converter_run), .result_valid(result_valid));
   acc_analog_model u_acc_analog_model (.positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .raw_sample(raw_sample));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task end_of_test;
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   task chk(string name, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   // 6 MHz converter ticks are unevenly spaced, so lengths get a small window
   task chk_near(string name, int e, int g);
      checks++;
      if (g < e - 3 || g > e + 3) begin
         n_errors++;
         $display("BAD %s expected %0d seen %0d", name, e, g);
      end
   endtask : chk_near

   task wr(logic [31:0] a, logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask : wr

   task rd(logic [31:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   task wait_valid(int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk);
         #1 cnt++;
      end while (result_valid !== 1'b1 && cnt < lim);
   endtask : wait_valid

   function automatic int cyc(int t, logic slow);
      return slow ? t * acc_pkg::ACC_CORE_MHZ / acc_pkg::ACC_SLOW_MHZ :
         t * acc_pkg::ACC_CORE_MHZ / acc_pkg::ACC_FAST_MHZ;
   endfunction : cyc

   function automatic logic [15:0] expect_res(logic [15:0] raw, logic [2:0] p,
         logic [15:0] off, logic [15:0] g);
      logic signed [16:0] q;
      logic signed [35:0] m;
      q = $signed(raw & (16'hffff << (9 - p))) + $signed(off);
      m = (q * $signed({1'b0, g})) >>> 15;
      if (m > 32767) return 16'h7fff;
      if (m < -32768) return 16'h8000;
      return m[15:0];
   endfunction : expect_res

   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      bus_req = '0;
      rst_b = 1'b0;
      n_errors = 0;
      checks = 0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(acc_pkg::ACC_RESULT_ADDR, rdat);
      chk("result reset", 32'h0, rdat);
      rd(acc_pkg::ACC_CONFIG_ADDR, rdat);
      chk("config reset", 32'h00001800, rdat);
      rd(acc_pkg::ACC_OFFSET_ADDR, rdat);
      chk("offset reset", 32'h0, rdat);
      rd(acc_pkg::ACC_GAIN_ADDR, rdat);
      chk("gain reset", 32'h00008000, rdat);
      rd(32'h4000d010, rdat);
      chk("unmapped", 32'h0, rdat);
      foreach (cases[i]) begin
         wr(acc_pkg::ACC_OFFSET_ADDR, {16'h0, cases[i].off});
         wr(acc_pkg::ACC_GAIN_ADDR, {16'h0, cases[i].g});
         // reserved bits always written as zero
         cfg = '{cases[i].p, 2'b00, cases[i].pos, cases[i].neg, cases[i].slow, 1'b0, 1'b1};
         wr(acc_pkg::ACC_CONFIG_ADDR, {16'h0, cfg});
         ticks = 32 << cases[i].p;
         #1 chk("pos sel", {28'h0, cases[i].pos}, {28'h0, positive_input_select});
         chk("neg sel", {28'h0, cases[i].neg}, {28'h0, negative_input_select});
         chk("slow", {31'h0, cases[i].slow}, {31'h0, slow_clock_select});
         chk("run", 32'h1, {31'h0, converter_run});
         wait_valid(20000, n);
         chk_near("first len", 21000 / 100 + cyc(2 * ticks, cases[i].slow), n);
         wait_valid(20000, n);
         chk_near("normal len", cyc(ticks, cases[i].slow), n);
         exp_res = expect_res(raw_sample, cases[i].p, cases[i].off, cases[i].g);
         rd(acc_pkg::ACC_RESULT_ADDR, rdat);
         chk("result", {16'h0, exp_res}, rdat);
         wr(acc_pkg::ACC_CONFIG_ADDR, {16'h0, cfg});
         wait_valid(20000, n);
         chk_near("rewrite len", cyc(2 * ticks, cases[i].slow), n);
         cfg.enable = 1'b0;
         wr(acc_pkg::ACC_CONFIG_ADDR, {16'h0, cfg});
         #1 chk("stopped", 32'h0, {31'h0, converter_run});
         wait_valid(300, n);
         chk("no result", 32'd300, n);
      end
      // result register ignores writes
      wr(acc_pkg::ACC_RESULT_ADDR, 32'h00001234);
      rd(acc_pkg::ACC_RESULT_ADDR, rdat);
      chk("result ro", {16'h0, exp_res}, rdat);
      end_of_test();
   end
endmodule : testbench
